// file: design/mrs_handler.sv
/*
 Slave-side request handler for a serial RTU link: frames bytes by line
 silence, filters by station, serves read and write holding register
 requests and builds normal, echo and exception responses with check value.
 Assumes a character layer on the same clock that delivers received bytes
 as one-cycle strobes, takes bytes to send with valid/ready and reports
 tx_busy while a character is on the line; a register store answers requests.
*/
`timescale 1ns/1ps
`include "mrs_defines.svh"

// Overview of operation
// - Frames are delimited by at least 3.5 character times of line silence.
// - The first frame byte is the station address, valid range 1 to 247.
// - Only frames matching the own station are answered; others are dropped silently.
// - Only function 03 (read registers) and 06 (write one register) are served.
// - A refused request is answered with function code plus 80 hex and a code.
// - Every frame ends with a two-byte check value, low byte first; a read reply cut short after its first word gets none.
// - The check value covers address, function code and all data bytes.
// - Read reply: address, 03, byte count twice the count, values high first.
// - A successful write is answered by echoing the request frame unchanged.
// - A register count above the limit raises an exception.
// - Code 02 when start address is an invalid register or start plus count exceeds the number of registers.
// - Code 01 when the function code is not supported.
// - Code 03 when a data value is not acceptable to the register.
// - Code 04 when the register store fails on a write or on the first word of a read.
// - Exception reply: address, modified function, one code byte, check value.
// - The own station comes from a setting of range 0 to 31.
module mrs_handler
    import mrs_pkg::*;
#(
    parameter int BAUD = `MRS_BAUD_DEF,
    parameter int NUM_REGS = `MRS_NUM_REGS,
    parameter logic [15:0] QTY_MAX = `MRS_QTY_MAX,
    parameter int BUF_DEPTH = 2,
    parameter longint GAP_CLKS = (longint'(`MRS_CLK_HZ) * `MRS_CHAR_BITS
        * `MRS_SILENCE_TENTHS + longint'(BAUD) * 10 - 1) / (longint'(BAUD) * 10)
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [4:0] station_number_setting,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_busy,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic hreq_valid,
    output mrs_hreq_t hreq,
    input wire mrs_hrsp_t hrsp
);
    localparam logic [31:0] GAP = 32'(GAP_CLKS);

    if (GAP_CLKS < 1 || GAP_CLKS > 64'h7FFFFFFF || NUM_REGS < 1 || NUM_REGS > 65536
        || QTY_MAX == 16'h0000 || QTY_MAX > 16'h007F)
    begin : g_bad_param
        $error("mrs_handler: parameter out of serviceable range");
    end

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? ((c >> 1) ^ `MRS_CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_step

    // Station setting arrives from outside the clock domain
    logic [4:0] st_meta;
    logic [4:0] st_sync;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_meta <= '0;
            st_sync <= '0;
        end
        else if (ce)
        begin
            st_meta <= station_number_setting;
            st_sync <= st_meta;
        end
    end

    mrs_state_t state, next_state;
    mrs_kind_t kind, next_kind;
    logic sync, next_sync;
    logic [31:0] idle_cnt, next_idle_cnt;
    logic [7:0] frame [`MRS_REQ_LEN];
    logic [7:0] next_frame [`MRS_REQ_LEN];
    logic [3:0] rx_len, next_rx_len;
    logic [15:0] rx_crc, next_rx_crc;
    logic [15:0] tx_crc, next_tx_crc;
    logic [7:0] exc_code, next_exc_code;
    logic [7:0] k, next_k;
    logic [6:0] widx, next_widx;
    logic [15:0] word, next_word;
    logic word_ok, next_word_ok;
    logic next_hreq_valid;
    mrs_hreq_t next_hreq;

    logic push;
    logic in_ready;
    logic buf_empty;
    logic [7:0] cur_byte;
    logic [7:0] body;
    logic silence;
    logic need_fetch;
    logic [15:0] start;
    logic [15:0] qty;
    logic [16:0] span_end;

    mrs_txbuf #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_txbuf (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(push),
        .in_data(cur_byte),
        .in_ready(in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready),
        .empty(buf_empty)
    );

    assign start = {frame[2], frame[3]};
    assign qty = {frame[4], frame[5]};
    assign span_end = {1'b0, start} + {1'b0, qty};
    assign silence = (idle_cnt == GAP);

    // Response byte selection
    always_comb
    begin
        unique case (kind)
            K_EXC: body = 8'(`MRS_EXC_BODY);
            K_ECHO: body = 8'(`MRS_ECHO_BODY);
            K_READ: body = 8'(`MRS_RD_HDR) + {qty[6:0], 1'b0};
        endcase
        need_fetch = (kind == K_READ) && (k >= 8'(`MRS_RD_HDR)) && (k < body)
            && k[0] && !word_ok;
        if (k == body)
            cur_byte = tx_crc[7:0];
        else if (k == body + 8'h01)
            cur_byte = tx_crc[15:8];
        else
        begin
            unique case (kind)
                K_EXC: cur_byte = (k == 8'h00) ? frame[0] :
                    (k == 8'h01) ? (frame[1] | `MRS_FC_EXC_FLAG) : exc_code;
                K_ECHO: cur_byte = frame[k[2:0]];
                K_READ: cur_byte = (k == 8'h00) ? frame[0] : (k == 8'h01) ? frame[1] :
                    (k == 8'h02) ? {qty[6:0], 1'b0} :
                    (k[0] ? word[15:8] : word[7:0]);
            endcase
        end
        push = (state == S_SEND) && !need_fetch;
    end

    always_comb
    begin
        next_state = state;
        next_kind = kind;
        next_sync = sync;
        next_frame = frame;
        next_rx_len = rx_len;
        next_rx_crc = rx_crc;
        next_tx_crc = tx_crc;
        next_exc_code = exc_code;
        next_k = k;
        next_widx = widx;
        next_word = word;
        next_word_ok = word_ok;
        next_hreq_valid = hreq_valid;
        next_hreq = hreq;

        // Silence counts only while the line is quiet in both directions
        if (rx_valid || tx_busy || !buf_empty || push)
            next_idle_cnt = '0;
        else if (silence)
            next_idle_cnt = idle_cnt;
        else
            next_idle_cnt = idle_cnt + 32'h1;

        if (silence)
            next_sync = 1'b1;
        if (rx_valid && state != S_RX)
            next_sync = 1'b0; // Bytes seen while busy mean a frame already underway

        unique case (state)
            S_RX:
            begin
                if (rx_valid && sync)
                begin
                    if (rx_len < 4'(`MRS_REQ_LEN))
                        next_frame[rx_len[2:0]] = rx_data;
                    if (rx_len <= 4'(`MRS_REQ_LEN))
                        next_rx_len = rx_len + 4'h1;
                    next_rx_crc = crc_step(rx_crc, rx_data);
                end
                else if (silence && rx_len != 4'h0)
                    next_state = S_EVAL;
            end
            S_EVAL:
            begin
                next_rx_len = '0;
                next_rx_crc = `MRS_CRC_INIT;
                next_state = S_SEND;
                next_kind = K_EXC;
                next_k = '0;
                next_tx_crc = `MRS_CRC_INIT;
                next_word_ok = 1'b0;
                next_widx = '0;
                // Residue over data plus check value is zero for a good frame
                if (rx_len < 4'(`MRS_MIN_LEN) || rx_crc != 16'h0000)
                    next_state = S_RX;
                else if (frame[0] == `MRS_BROADCAST || frame[0] > `MRS_STATION_MAX)
                    next_state = S_RX;
                else if (frame[0] != {3'b000, st_sync})
                    next_state = S_RX;
                else if (frame[1] != `MRS_FC_READ && frame[1] != `MRS_FC_WRITE)
                    next_exc_code = `MRS_EXC_FUNC;
                else if (rx_len != 4'(`MRS_REQ_LEN))
                    next_exc_code = `MRS_EXC_VALUE;
                else if (frame[1] == `MRS_FC_READ)
                begin
                    if (qty == 16'h0000 || qty > QTY_MAX)
                        next_exc_code = `MRS_EXC_VALUE;
                    else if (32'(start) >= 32'(NUM_REGS) || 32'(span_end) > 32'(NUM_REGS))
                        next_exc_code = `MRS_EXC_ADDR;
                    else
                    begin
                        next_kind = K_READ;
                        next_state = S_FETCH;
                        next_hreq_valid = 1'b1;
                        next_hreq = '{wr: 1'b0, addr: start, wdata: 16'h0000};
                    end
                end
                else if (32'(start) >= 32'(NUM_REGS))
                    next_exc_code = `MRS_EXC_ADDR;
                else
                begin
                    next_state = S_WRITE;
                    next_hreq_valid = 1'b1;
                    next_hreq = '{wr: 1'b1, addr: start, wdata: qty};
                end
            end
            S_WRITE:
            begin
                if (hrsp.ack)
                begin
                    next_hreq_valid = 1'b0;
                    next_state = S_SEND;
                    if (hrsp.err)
                        next_exc_code = `MRS_EXC_FAIL;
                    else if (hrsp.bad_value)
                        next_exc_code = `MRS_EXC_VALUE;
                    else
                        next_kind = K_ECHO;
                end
            end
            S_FETCH:
            begin
                if (hrsp.ack)
                begin
                    next_hreq_valid = 1'b0;
                    next_widx = widx + 7'h01;
                    next_state = S_SEND;
                    if (hrsp.err || hrsp.bad_value)
                    begin
                        // Header already out after the first word: reply is cut short
                        if (k == 8'h00)
                        begin
                            next_kind = K_EXC;
                            next_exc_code = `MRS_EXC_FAIL;
                        end
                        else
                            next_state = S_RX;
                    end
                    else
                    begin
                        next_word = hrsp.rdata;
                        next_word_ok = 1'b1;
                    end
                end
            end
            S_SEND:
            begin
                if (need_fetch)
                begin
                    next_state = S_FETCH;
                    next_hreq_valid = 1'b1;
                    next_hreq = '{wr: 1'b0, addr: start + {9'h000, widx}, wdata: 16'h0000};
                end
                else if (in_ready)
                begin
                    if (k < body)
                        next_tx_crc = crc_step(tx_crc, cur_byte);
                    if (kind == K_READ && k > 8'(`MRS_RD_HDR) && !k[0])
                        next_word_ok = 1'b0;
                    next_k = k + 8'h01;
                    if (k == body + 8'h01)
                        next_state = S_RX;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= S_RX;
            kind <= K_EXC;
            sync <= 1'b0;
            idle_cnt <= '0;
            for (int i = 0; i < `MRS_REQ_LEN; i++)
                frame[i] <= 8'h00;
            rx_len <= '0;
            rx_crc <= `MRS_CRC_INIT;
            tx_crc <= `MRS_CRC_INIT;
            exc_code <= 8'h00;
            k <= '0;
            widx <= '0;
            word <= 16'h0000;
            word_ok <= 1'b0;
            hreq_valid <= 1'b0;
            hreq <= '0;
        end
        else if (ce)
        begin
            state <= next_state;
            kind <= next_kind;
            sync <= next_sync;
            idle_cnt <= next_idle_cnt;
            frame <= next_frame;
            rx_len <= next_rx_len;
            rx_crc <= next_rx_crc;
            tx_crc <= next_tx_crc;
            exc_code <= next_exc_code;
            k <= next_k;
            widx <= next_widx;
            word <= next_word;
            word_ok <= next_word_ok;
            hreq_valid <= next_hreq_valid;
            hreq <= next_hreq;
        end
    end

endmodule : mrs_handler

// file: design/mrs_defines.svh
/*
 Constants of the serial request handler: frame layout, function and
 exception codes, check value parameters and silence timing.
 Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

// Timing: clock rate, default line rate, bits per character
`define MRS_CLK_HZ 250000000
`define MRS_BAUD_DEF 9600
`define MRS_CHAR_BITS 11
// Frame silence is 3.5 character times, held here in tenths
`define MRS_SILENCE_TENTHS 35

// Frame layout
`define MRS_REQ_LEN 8
`define MRS_MIN_LEN 4
`define MRS_ECHO_BODY 6
`define MRS_EXC_BODY 3
`define MRS_RD_HDR 3

// Function and exception codes
`define MRS_FC_READ 8'h03
`define MRS_FC_WRITE 8'h06
`define MRS_FC_EXC_FLAG 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_EXC_FAIL 8'h04

// Station addresses
`define MRS_BROADCAST 8'h00
`define MRS_STATION_MAX 8'hF7

// Check value
`define MRS_CRC_POLY 16'hA001
`define MRS_CRC_INIT 16'hFFFF

// Register window defaults
`define MRS_QTY_MAX 16'h007D
`define MRS_NUM_REGS 256

`endif

// file: design/mrs_pkg.sv
/*
 Types shared by the request handler and its output buffer.
 Assumes mrs_defines.svh is available on the include path.
*/
package mrs_pkg;

    typedef enum logic [4:0] {
        S_RX    = 5'b00001,
        S_EVAL  = 5'b00010,
        S_WRITE = 5'b00100,
        S_FETCH = 5'b01000,
        S_SEND  = 5'b10000
    } mrs_state_t;

    typedef enum logic [2:0] {
        K_EXC  = 3'b001,
        K_ECHO = 3'b010,
        K_READ = 3'b100
    } mrs_kind_t;

    // Request to the holding register store behind the handler
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mrs_hreq_t;

    // Answer from the holding register store
    typedef struct packed {
        logic ack;
        logic err;
        logic bad_value;
        logic [15:0] rdata;
    } mrs_hrsp_t;

endpackage : mrs_pkg

// file: design/mrs_txbuf.sv
/*
 Small FIFO between the response generator and the character transmitter.
 Assumes one clock, a clock enable that freezes it, and a power-of-two depth.
*/
`timescale 1ns/1ps
module mrs_txbuf
    import mrs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic empty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_param
        $error("mrs_txbuf: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic do_push;
    logic do_pop;

    assign empty = (wptr == rptr);
    assign in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
    assign out_valid = !empty;
    assign out_data = mem[rptr[AW-1:0]];

    always_comb
    begin
        do_push = in_valid && in_ready;
        do_pop = out_valid && out_ready;
        next_wptr = do_push ? wptr + 1'b1 : wptr;
        next_rptr = do_pop ? rptr + 1'b1 : rptr;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wptr <= '0;
            rptr <= '0;
        end
        else if (ce)
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    // Storage has no reset: only entries between the pointers are ever read
    always_ff @(posedge clk_sys)
    begin
        if (ce && do_push)
            mem[wptr[AW-1:0]] <= in_data;
    end

endmodule : mrs_txbuf

// file: sim/mrs_handler_sva.sv
/*
 Checker for the serial request handler: port-level timing and framing.
 Assumes it is bound to mrs_handler and sees only that module's ports.
*/
`timescale 1ns/1ps
module mrs_handler_sva
    import mrs_pkg::*;
#(
    parameter int NUM_REGS = 256,
    parameter longint GAP_CLKS = 20
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [4:0] station_number_setting,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_busy,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic hreq_valid,
    input wire mrs_hreq_t hreq,
    input wire mrs_hrsp_t hrsp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Cycles since the last received byte, saturating so it never wraps
    int quiet;
    int rx_idx;
    int tx_cnt;
    logic [7:0] fc;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            quiet <= 0;
            rx_idx <= 0;
            tx_cnt <= 0;
            fc <= 8'h00;
        end
        else
        begin
            quiet <= rx_valid ? 0 : (quiet < 1000000 ? quiet + 1 : quiet);
            if (rx_valid)
                rx_idx <= (quiet >= GAP_CLKS) ? 1 : rx_idx + 1;
            if (rx_valid && rx_idx == 1 && quiet < GAP_CLKS)
                fc <= rx_data;
            if (rx_valid)
                tx_cnt <= 0;
            else if (tx_valid && tx_ready && ce)
                tx_cnt <= tx_cnt + 1;
        end
    end

    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit byte changed before it was taken");
    chk_req_hold: assert property (hreq_valid && !hrsp.ack |=> hreq_valid && $stable(hreq))
        else $error("store request changed before its answer");
    chk_req_drop: assert property (hreq_valid && hrsp.ack && ce |=> !hreq_valid)
        else $error("store request held after its answer");
    chk_reset_quiet: assert property ($rose(arst_n) |-> !tx_valid && !hreq_valid)
        else $error("activity at the first edge after reset");
    chk_reply_gap: assert property ($rose(tx_valid) |-> quiet >= GAP_CLKS)
        else $error("reply started before end-of-frame silence");
    chk_req_gap: assert property ($rose(hreq_valid) |-> quiet >= GAP_CLKS)
        else $error("request served before end-of-frame silence");
    chk_reply_station: assert property (tx_valid && tx_cnt == 0
        |-> tx_data == {3'b000, station_number_setting})
        else $error("reply does not start with own station");
    chk_func_echo: assert property (tx_valid && tx_cnt == 1 |-> tx_data[6:0] == fc[6:0])
        else $error("reply function differs from request");
    chk_req_range: assert property (hreq_valid |-> hreq.addr < NUM_REGS)
        else $error("store request outside register window");

    cov_read: cover property (hreq_valid && !hreq.wr && hrsp.ack);
    cov_write: cover property (hreq_valid && hreq.wr && hrsp.ack);
    cov_exc: cover property (tx_valid && tx_cnt == 1 && tx_data[7]);
endmodule : mrs_handler_sva

// file: sim/mrs_master_model.sv
/*
 Far-side model: the master's character layer on the shared serial line.
 Assumes the bench calls send() and reads got; slow stalls the transmitter.
*/
`timescale 1ns/1ps
module mrs_master_model #(
    parameter int CHAR_CLKS = 3
)
(
    input wire logic clk_sys,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_busy
);
    logic [7:0] got[$];
    int busy_cnt = 0;

    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
    end

    assign tx_busy = busy_cnt != 0;
    assign tx_ready = !(slow && tx_busy);

    always @(posedge clk_sys)
    begin
        if (tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
            busy_cnt <= CHAR_CLKS;
        end
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    // Caller keeps the line silent between frames
    task automatic send(input logic [7:0] b[$], input logic bad_crc);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad_crc};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i])
        begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_data <= b[i];
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        // Idle line must not keep showing the last byte
        rx_data <= ~b[b.size()-1];
    endtask : send
endmodule : mrs_master_model

// file: sim/tb.sv
/*
 Self-checking bench for the request handler with a master model and a
 holding register store model. Assumes a shortened silence of GAP cycles.
*/
`timescale 1ns/1ps
module tb;
    import mrs_pkg::*;
    localparam int GAP = 20;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [4:0] station = 5'h01;
    logic slow = 1'b0;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_busy;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic hreq_valid;
    mrs_hreq_t hreq;
    mrs_hrsp_t hrsp = '0;
    logic [15:0] mem [256];
    int err_total = 0;
    int num_checks = 0;

    always #2 clk_sys = ~clk_sys;

    mrs_handler #(.GAP_CLKS(GAP)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
        .station_number_setting(station), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_busy(tx_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .hreq_valid(hreq_valid), .hreq(hreq), .hrsp(hrsp));
    mrs_master_model i_master (.clk_sys(clk_sys), .slow(slow), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .tx_busy(tx_busy));

    // Store: answers one cycle late; address 40 fails, value FFFF is refused
    always @(posedge clk_sys)
    begin
        hrsp <= '0;
        if (hreq_valid && !hrsp.ack)
        begin
            hrsp.ack <= 1'b1;
            hrsp.err <= hreq.addr == 16'h0040;
            hrsp.bad_value <= hreq.wr && hreq.wdata == 16'hFFFF;
            hrsp.rdata <= mem[hreq.addr[7:0]];
            if (hreq.wr && hreq.addr != 16'h0040 && hreq.wdata != 16'hFFFF)
                mem[hreq.addr[7:0]] <= hreq.wdata;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic xact(input logic [7:0] req[$], input logic [7:0] rsp[$], input logic bad);
        logic [15:0] c;
        int n;
        i_master.got.delete();
        i_master.send(req, bad);
        if (rsp.size() != 0)
        begin
            c = i_master.crc16(rsp);
            rsp.push_back(c[7:0]);
            rsp.push_back(c[15:8]);
        end
        n = 0;
        while (n < 3000 && i_master.got.size() < rsp.size())
        begin
            @(posedge clk_sys);
            n++;
        end
        repeat (3 * GAP) @(posedge clk_sys);
        check("reply length", 16'(i_master.got.size()), 16'(rsp.size()));
        foreach (rsp[i])
            if (i < i_master.got.size())
                check("reply byte", i_master.got[i], rsp[i]);
    endtask : xact

    task automatic t_read();
        slow <= 1'b1;
        xact('{8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h02},
            '{8'h01, 8'h03, 8'h04, 8'h5A, 8'h06, 8'h5A, 8'h07}, 1'b0);
        slow <= 1'b0;
    endtask : t_read

    task automatic t_write();
        // Clock enable dropped during the end-of-frame silence only delays the reply
        fork
            xact('{8'h01, 8'h06, 8'h00, 8'h15, 8'hFC, 8'h18},
                '{8'h01, 8'h06, 8'h00, 8'h15, 8'hFC, 8'h18}, 1'b0);
            begin
                repeat (14) @(posedge clk_sys);
                ce <= 1'b0;
                repeat (6) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join
        xact('{8'h01, 8'h03, 8'h00, 8'h15, 8'h00, 8'h01},
            '{8'h01, 8'h03, 8'h02, 8'hFC, 8'h18}, 1'b0);
    endtask : t_write

    task automatic t_exc();
        xact('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h82, 8'h01}, 1'b0);
        xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7E}, '{8'h01, 8'h83, 8'h03}, 1'b0);
        xact('{8'h01, 8'h03, 8'h00, 8'hFF, 8'h00, 8'h02}, '{8'h01, 8'h83, 8'h02}, 1'b0);
        xact('{8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h86, 8'h02}, 1'b0);
        xact('{8'h01, 8'h06, 8'h00, 8'h10, 8'hFF, 8'hFF}, '{8'h01, 8'h86, 8'h03}, 1'b0);
        xact('{8'h01, 8'h06, 8'h00, 8'h40, 8'h00, 8'h01}, '{8'h01, 8'h86, 8'h04}, 1'b0);
        xact('{8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, '{8'h01, 8'h83, 8'h04}, 1'b0);
    endtask : t_exc

    task automatic t_filter();
        logic [7:0] rsp[$];
        xact('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1'b0);
        xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1'b1);
        xact('{8'h00, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, '{}, 1'b0);
        station <= 5'h1F;
        repeat (4) @(posedge clk_sys);
        // Largest quantity ending exactly on the last register
        rsp = '{8'h1F, 8'h03, 8'hFA};
        for (int r = 8'h83; r <= 8'hFF; r++)
        begin
            rsp.push_back(8'h5A);
            rsp.push_back(r[7:0]);
        end
        xact('{8'h1F, 8'h03, 8'h00, 8'h83, 8'h00, 8'h7D}, rsp, 1'b0);
    endtask : t_filter

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = {8'h5A, i[7:0]};
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (GAP + 4) @(posedge clk_sys);
        t_read();
        t_write();
        t_exc();
        t_filter();
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
endmodule : tb

bind mrs_handler mrs_handler_sva #(.NUM_REGS(NUM_REGS), .GAP_CLKS(GAP_CLKS)) i_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .station_number_setting(station_number_setting), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_busy(tx_busy), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .hreq_valid(hreq_valid), .hreq(hreq), .hrsp(hrsp));
